// file: verilog/trng_pkg.sv
package trng_pkg;
   // =====================================================
   // word and post-processing
   localparam int WORD_W = 16;
   localparam int WCNT_W = 5;
   localparam logic [WCNT_W-1:0] WCNT_LAST = 5'h0F;
   // =====================================================
   // total-failure (repetition) check, in raw bits
   localparam int RCT_W = 6;
   localparam logic [RCT_W-1:0] RCT_LIMIT = 6'h1F;
   // quarantine of a finished word, in raw bits
   localparam logic [RCT_W-1:0] QUAR_LEN = 6'h1F;
   // =====================================================
   // statistical windows, in raw bits
   localparam int WIN_W = 11;
   localparam logic [WIN_W-1:0] WIN_LAST = 11'h3FF;
   localparam logic [WIN_W-1:0] MONO_LO = 11'h1B8;
   localparam logic [WIN_W-1:0] MONO_HI = 11'h248;
   localparam logic [WIN_W-1:0] TRAN_LO = 11'h180;
   localparam logic [WIN_W-1:0] TRAN_HI = 11'h280;
   // =====================================================
   // run states
   typedef enum logic [3:0] {
      TRNG_IDLE = 4'b0001,
      TRNG_START = 4'b0010,
      TRNG_RUN = 4'b0100,
      TRNG_FAIL = 4'b1000
   } trng_state_t;
endpackage

// file: verilog/trng_window_test.sv
`timescale 1ns/10ps
// =====================================================
// windowed count test: counts ones over a fixed window
module trng_window_test #(
   parameter logic [10:0] P_LO = 11'h000,
   parameter logic [10:0] P_HI = 11'h7FF
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_clear,
   input wire logic i_valid,
   input wire logic i_bit,
   output logic o_done,
   output logic o_pass
);
   logic [trng_pkg::WIN_W-1:0] pos_q, pos_d;
   logic [trng_pkg::WIN_W-1:0] ones_q, ones_d;
   logic [trng_pkg::WIN_W-1:0] ones_now;
   logic done_q, done_d;
   logic pass_q, pass_d;

   always_comb begin
      pos_d = pos_q;
      ones_d = ones_q;
      done_d = 1'b0;
      pass_d = pass_q;
      ones_now = ones_q + {{(trng_pkg::WIN_W-1){1'b0}}, i_bit};
      if (i_clear) begin
         pos_d = '0;
         ones_d = '0;
         pass_d = 1'b0;
      end else if (i_valid) begin
         if (pos_q == trng_pkg::WIN_LAST) begin
            pos_d = '0;
            ones_d = '0;
            done_d = 1'b1;
            pass_d = (ones_now >= P_LO) && (ones_now <= P_HI);
         end else begin
            pos_d = pos_q + 11'h001;
            ones_d = ones_now;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pos_q <= '0;
         ones_q <= '0;
         done_q <= 1'b0;
         pass_q <= 1'b0;
      end else if (i_ce) begin
         pos_q <= pos_d;
         ones_q <= ones_d;
         done_q <= done_d;
         pass_q <= pass_d;
      end
   end

   assign o_done = done_q;
   assign o_pass = pass_q;
endmodule // trng_window_test

// file: verilog/trng_health_gate.sv
`timescale 1ns/10ps
// What this block does
// - on start, check source for total failure; no words while failed
// - after total failure, withhold every word built from later raw bits
// - online statistical test on raw bits at start-up and during operation
// - no output until start-up test passes, nor after any defect
// - online test runs continuously, window after window, bounded detection time
// - output bits debiased by pairwise xor to keep entropy above 0.997
// - alternative variant: degradation health test; failure makes generator unusable
// - alternative variant: malfunction check of post-processing and control; stop
// - software-reported test failure shuts generator down, error flag raised
module trng_health_gate (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_raw_bit,
   input wire logic i_enable,
   input wire logic i_alt_variant,
   input wire logic i_sw_test_fail,
   input wire logic i_fail_clear,
   output logic [trng_pkg::WORD_W-1:0] o_word,
   output logic o_word_valid,
   output logic o_running,
   output logic o_total_fail,
   output logic o_online_fail,
   output logic o_health_fail,
   output logic o_malfunction,
   output logic o_fail_sticky
);
   // =====================================================
   // raw input synchroniser
   logic meta_q, raw_q, prev_q;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= 1'b0;
         raw_q <= 1'b0;
         prev_q <= 1'b0;
      end else if (i_ce) begin
         meta_q <= i_raw_bit;
         raw_q <= meta_q;
         prev_q <= raw_q;
      end
   end

   // =====================================================
   // state and detections
   trng_pkg::trng_state_t state_q, state_d;
   logic active, clear_tests;
   logic mono_done, mono_pass, tran_done, tran_pass;
   logic [trng_pkg::RCT_W-1:0] rct_q, rct_d;
   logic total_fail, online_fail, health_fail, malfunction, illegal_state;
   logic online_fail_q, online_fail_d, health_fail_q, health_fail_d;
   logic mal_q, mal_d, sticky_q, sticky_d, fail_any;

   assign active = state_q == trng_pkg::TRNG_START || state_q == trng_pkg::TRNG_RUN;
   assign clear_tests = !active;

   trng_window_test #(.P_LO(trng_pkg::MONO_LO), .P_HI(trng_pkg::MONO_HI)) u_mono (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_clear(clear_tests),
      .i_valid(active),
      .i_bit(raw_q),
      .o_done(mono_done),
      .o_pass(mono_pass)
   );

   trng_window_test #(.P_LO(trng_pkg::TRAN_LO), .P_HI(trng_pkg::TRAN_HI)) u_tran (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_clear(clear_tests),
      .i_valid(active),
      .i_bit(raw_q ^ prev_q),
      .o_done(tran_done),
      .o_pass(tran_pass)
   );

   // =====================================================
   // word assembly, quarantine and output
   logic pair_half_q, pair_half_d, pair_first_q, pair_first_d;
   logic pp_valid, pp_bit;
   logic [trng_pkg::WORD_W-1:0] shift_q, shift_d, pend_q, pend_d, word_q, word_d;
   logic [trng_pkg::WCNT_W-1:0] wcnt_q, wcnt_d;
   logic par_q, par_d, pend_full_q, pend_full_d, valid_q, valid_d;
   logic [trng_pkg::RCT_W-1:0] quar_q, quar_d;
   logic word_done, par_err;

   assign total_fail = active && (rct_q >= trng_pkg::RCT_LIMIT);
   assign online_fail = mono_done && !mono_pass;
   assign health_fail = i_alt_variant && tran_done && !tran_pass;
   assign pp_valid = (state_q == trng_pkg::TRNG_RUN) && pair_half_q;
   assign pp_bit = pair_first_q ^ raw_q;
   assign illegal_state = state_q != trng_pkg::TRNG_IDLE && state_q != trng_pkg::TRNG_START
      && state_q != trng_pkg::TRNG_RUN && state_q != trng_pkg::TRNG_FAIL;
   assign word_done = pp_valid && (wcnt_q == trng_pkg::WCNT_LAST);
   assign par_err = word_done
      && ((^{shift_q[trng_pkg::WORD_W-2:0], pp_bit}) != (par_q ^ pp_bit));
   assign malfunction = i_alt_variant && (par_err || illegal_state);
   assign fail_any = total_fail || online_fail || health_fail || malfunction
      || i_sw_test_fail;

   always_comb begin
      rct_d = rct_q;
      if (!active) begin
         rct_d = '0;
      end else if (raw_q == prev_q) begin
         if (rct_q < trng_pkg::RCT_LIMIT) begin
            rct_d = rct_q + 6'h01;
         end
      end else begin
         rct_d = '0;
      end
   end

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         trng_pkg::TRNG_IDLE: begin
            if (i_enable) begin
               state_d = trng_pkg::TRNG_START;
            end
         end
         trng_pkg::TRNG_START: begin
            if (fail_any) begin
               state_d = trng_pkg::TRNG_FAIL;
            end else if (!i_enable) begin
               state_d = trng_pkg::TRNG_IDLE;
            end else if (mono_done && (!i_alt_variant || tran_pass)) begin
               state_d = trng_pkg::TRNG_RUN;
            end
         end
         trng_pkg::TRNG_RUN: begin
            if (fail_any) begin
               state_d = trng_pkg::TRNG_FAIL;
            end else if (!i_enable) begin
               state_d = trng_pkg::TRNG_IDLE;
            end
         end
         trng_pkg::TRNG_FAIL: begin
            if (!i_enable) begin
               state_d = trng_pkg::TRNG_IDLE;
            end
         end
         default: begin
            state_d = trng_pkg::TRNG_FAIL;
         end
      endcase
   end

   always_comb begin
      online_fail_d = online_fail_q;
      health_fail_d = health_fail_q;
      mal_d = mal_q;
      sticky_d = sticky_q;
      if (state_q == trng_pkg::TRNG_IDLE && i_enable) begin
         online_fail_d = 1'b0;
         health_fail_d = 1'b0;
         mal_d = 1'b0;
      end
      if (i_fail_clear) begin
         sticky_d = 1'b0;
      end
      online_fail_d = online_fail_d || online_fail;
      health_fail_d = health_fail_d || health_fail;
      mal_d = mal_d || malfunction;
      if (fail_any) begin
         sticky_d = 1'b1;
      end
   end

   always_comb begin
      pair_half_d = pair_half_q;
      pair_first_d = pair_first_q;
      shift_d = shift_q;
      wcnt_d = wcnt_q;
      par_d = par_q;
      pend_d = pend_q;
      pend_full_d = pend_full_q;
      quar_d = quar_q;
      word_d = word_q;
      valid_d = 1'b0;
      if (state_q != trng_pkg::TRNG_RUN || fail_any) begin
         pair_half_d = 1'b0;
         shift_d = '0;
         wcnt_d = '0;
         par_d = 1'b0;
         pend_full_d = 1'b0;
         quar_d = '0;
      end else begin
         pair_half_d = !pair_half_q;
         if (!pair_half_q) begin
            pair_first_d = raw_q;
         end else begin
            shift_d = {shift_q[trng_pkg::WORD_W-2:0], pp_bit};
            par_d = par_q ^ pp_bit;
            wcnt_d = word_done ? '0 : wcnt_q + 5'h01;
         end
         if (pend_full_q) begin
            if (quar_q == trng_pkg::QUAR_LEN) begin
               word_d = pend_q;
               valid_d = 1'b1;
               pend_full_d = 1'b0;
            end else begin
               quar_d = quar_q + 6'h01;
            end
         end
         if (word_done) begin
            pend_d = shift_d;
            pend_full_d = 1'b1;
            quar_d = '0;
            par_d = 1'b0;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= trng_pkg::TRNG_IDLE;
         rct_q <= '0;
         online_fail_q <= 1'b0;
         health_fail_q <= 1'b0;
         mal_q <= 1'b0;
         sticky_q <= 1'b0;
      end else if (i_ce) begin
         state_q <= state_d;
         rct_q <= rct_d;
         online_fail_q <= online_fail_d;
         health_fail_q <= health_fail_d;
         mal_q <= mal_d;
         sticky_q <= sticky_d;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pair_half_q <= 1'b0;
         pair_first_q <= 1'b0;
         shift_q <= '0;
         wcnt_q <= '0;
         par_q <= 1'b0;
         pend_q <= '0;
         pend_full_q <= 1'b0;
         quar_q <= '0;
         word_q <= '0;
         valid_q <= 1'b0;
      end else if (i_ce) begin
         pair_half_q <= pair_half_d;
         pair_first_q <= pair_first_d;
         shift_q <= shift_d;
         wcnt_q <= wcnt_d;
         par_q <= par_d;
         pend_q <= pend_d;
         pend_full_q <= pend_full_d;
         quar_q <= quar_d;
         word_q <= word_d;
         valid_q <= valid_d;
      end
   end

   // =====================================================
   // outputs
   assign o_word = word_q;
   assign o_word_valid = valid_q;
   assign o_running = state_q == trng_pkg::TRNG_RUN;
   assign o_total_fail = total_fail;
   assign o_online_fail = online_fail_q;
   assign o_health_fail = health_fail_q;
   assign o_malfunction = mal_q;
   assign o_fail_sticky = sticky_q;
endmodule // trng_health_gate

// file: bench/trng_src_model.sv
`timescale 1ns/10ps
// =====================================================
// entropy source model, one raw bit per cycle
module trng_src_model (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic [1:0] i_mode,
   output logic o_raw_bit
);
   logic [15:0] lfsr_q;
   logic [15:0] lfsr_d;
   logic [1:0] pat_q;
   logic [1:0] pat_d;
   always_comb begin
      lfsr_d = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      pat_d = pat_q + 2'h1;
      case (i_mode)
         2'h0: o_raw_bit = lfsr_q[15];
         2'h1: o_raw_bit = 1'b0;
         2'h2: o_raw_bit = (pat_q != 2'h3);
         default: o_raw_bit = pat_q[0];
      endcase
   end
   always_ff @(negedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lfsr_q <= 16'hACE1;
         pat_q <= 2'h0;
      end else begin
         lfsr_q <= lfsr_d;
         pat_q <= pat_d;
      end
   end
endmodule // trng_src_model

// file: bench/trng_gate_chk.sv
`timescale 1ns/10ps
// =====================================================
// port checker
module trng_gate_chk (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_raw_bit,
   input wire logic i_enable,
   input wire logic i_alt_variant,
   input wire logic i_sw_test_fail,
   input wire logic i_fail_clear,
   input wire logic [trng_pkg::WORD_W-1:0] o_word,
   input wire logic o_word_valid,
   input wire logic o_running,
   input wire logic o_total_fail,
   input wire logic o_online_fail,
   input wire logic o_health_fail,
   input wire logic o_malfunction,
   input wire logic o_fail_sticky
);
   logic [10:0] en_cnt_q;
   logic [10:0] en_cnt_d;
   always_comb begin
      en_cnt_d = en_cnt_q;
      if (!i_enable) begin
         en_cnt_d = 11'h000;
      end else if (i_ce && en_cnt_q != 11'h7FF) begin
         en_cnt_d = en_cnt_q + 11'h001;
      end
   end
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         en_cnt_q <= 11'h000;
      end else begin
         en_cnt_q <= en_cnt_d;
      end
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   a_word_in_run: assert property (o_word_valid |-> o_running)
      else $error("word shown outside run");
   a_startup_wait: assert property ($rose(o_running) |-> en_cnt_q >= 11'h400)
      else $error("run began before start-up window");
   a_tf_no_word: assert property (o_total_fail |=> !o_word_valid [*8])
      else $error("word after total failure");
   a_tf_stop: assert property (o_total_fail |=> !o_running)
      else $error("still running after total failure");
   a_online_stop: assert property (o_online_fail |=> !o_running && !o_word_valid)
      else $error("output after online defect");
   a_sticky_set: assert property (o_total_fail |=> o_fail_sticky)
      else $error("sticky flag not set");
   a_sticky_hold: assert property (o_fail_sticky && !i_fail_clear |=> o_fail_sticky)
      else $error("sticky flag lost");
   a_sw_stop: assert property (i_sw_test_fail && i_ce |=> !o_running && o_fail_sticky)
      else $error("no shutdown on software failure");
   a_health_alt: assert property ($rose(o_health_fail) |-> $past(i_alt_variant))
      else $error("health failure outside variant");
   a_malf_alt: assert property ($rose(o_malfunction) |-> $past(i_alt_variant))
      else $error("malfunction outside variant");
   a_word_pulse: assert property (o_word_valid |=> !o_word_valid [*8])
      else $error("words too close");
   c_run: cover property ($rose(o_running));
   c_word: cover property (o_word_valid);
   c_online: cover property ($rose(o_online_fail));
   c_health: cover property ($rose(o_health_fail));
endmodule // trng_gate_chk
bind trng_health_gate trng_gate_chk chk_u (.i_mclk, .i_rst_n, .i_ce, .i_raw_bit, .i_enable,
   .i_alt_variant, .i_sw_test_fail, .i_fail_clear, .o_word, .o_word_valid, .o_running,
   .o_total_fail, .o_online_fail, .o_health_fail, .o_malfunction, .o_fail_sticky);

// file: bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   logic i_mclk, i_rst_n, i_ce, i_enable, i_alt_variant, i_sw_test_fail, i_fail_clear;
   logic raw_bit;
   logic [1:0] mode;
   logic [trng_pkg::WORD_W-1:0] o_word;
   logic o_word_valid, o_running, o_total_fail, o_online_fail;
   logic o_health_fail, o_malfunction, o_fail_sticky;
   int err_count;
   int cmp_count;
   int wcnt;
   trng_src_model src_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_mode(mode), .o_raw_bit(raw_bit));
   trng_health_gate dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_raw_bit(raw_bit),
      .i_enable(i_enable), .i_alt_variant(i_alt_variant), .i_sw_test_fail(i_sw_test_fail),
      .i_fail_clear(i_fail_clear), .o_word(o_word), .o_word_valid(o_word_valid),
      .o_running(o_running), .o_total_fail(o_total_fail), .o_online_fail(o_online_fail),
      .o_health_fail(o_health_fail), .o_malfunction(o_malfunction), .o_fail_sticky(o_fail_sticky));
   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end
   task automatic check(input string nm, input logic e, input logic g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: pick = o_running;
         1: pick = o_word_valid;
         2: pick = o_total_fail;
         3: pick = o_online_fail;
         default: pick = o_health_fail;
      endcase
   endfunction
   task automatic wait_for(input int s, input int lim);
      wcnt = 0;
      for (int k = 0; k < lim; k++) begin
         @(negedge i_mclk);
         if (o_word_valid === 1'b1) wcnt++;
         if (pick(s) === 1'b1) break;
      end
   endtask
   task automatic start(input logic [1:0] m, input logic alt);
      @(negedge i_mclk);
      i_enable = 1'b0;
      mode = m;
      i_alt_variant = alt;
      repeat (2) @(negedge i_mclk);
      i_enable = 1'b1;
   endtask
   task t_good;
      start(2'h0, 1'b0);
      wait_for(0, 1200);
      check("running", 1'b1, o_running);
      check("early_word", 1'b0, wcnt != 0);
      wait_for(1, 100);
      check("word_valid", 1'b1, o_word_valid);
   endtask
   task t_total;
      mode = 2'h1;
      wait_for(2, 40);
      check("total_fail", 1'b1, o_total_fail);
      @(negedge i_mclk);
      check("running", 1'b0, o_running);
      check("sticky", 1'b1, o_fail_sticky);
      wait_for(1, 100);
      check("late_word", 1'b0, o_word_valid);
      start(2'h1, 1'b0);
      wait_for(2, 40);
      check("start_total_fail", 1'b1, o_total_fail);
   endtask
   task t_online;
      start(2'h2, 1'b0);
      wait_for(3, 1200);
      check("online_fail", 1'b1, o_online_fail);
      check("running", 1'b0, o_running);
   endtask
   task t_alt;
      start(2'h3, 1'b1);
      wait_for(4, 1200);
      check("health_fail", 1'b1, o_health_fail);
      check("running", 1'b0, o_running);
      start(2'h0, 1'b1);
      wait_for(0, 1200);
      check("alt_running", 1'b1, o_running);
      check("malfunction", 1'b0, o_malfunction);
   endtask
   task t_sw;
      i_fail_clear = 1'b1;
      @(negedge i_mclk);
      i_fail_clear = 1'b0;
      check("sticky_clear", 1'b0, o_fail_sticky);
      i_sw_test_fail = 1'b1;
      @(negedge i_mclk);
      i_sw_test_fail = 1'b0;
      check("sw_running", 1'b0, o_running);
      check("sw_sticky", 1'b1, o_fail_sticky);
   endtask
   task t_debias;
      start(2'h3, 1'b0);
      wait_for(0, 1200);
      check("debias_running", 1'b1, o_running);
      wait_for(1, 100);
      check("debias_valid", 1'b1, o_word_valid);
      cmp_count++;
      if (o_word !== 16'hFFFF) begin
         err_count++;
         $display("ERROR word expected %h seen %h", 16'hFFFF, o_word);
      end
   endtask
   initial begin
      repeat (20000) @(posedge i_mclk);
      err_count++;
      give_verdict;
   end
   initial begin
      err_count = 0;
      cmp_count = 0;
      wcnt = 0;
      i_rst_n = 1'b0;
      i_ce = 1'b1;
      i_enable = 1'b0;
      i_alt_variant = 1'b0;
      i_sw_test_fail = 1'b0;
      i_fail_clear = 1'b0;
      mode = 2'h0;
      repeat (8) @(negedge i_mclk);
      i_rst_n = 1'b1;
      t_good;
      t_total;
      t_online;
      t_alt;
      t_sw;
      t_debias;
      give_verdict;
   end
endmodule // tb_top
